/* File: pmb_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// External program memory, boot EPROM and ROM
module pmb_mem_model
  import pmb_pkg::*;
(
  input wire logic        clk,
  input wire pmb_ext_t    ext,
  input wire logic [12:0] rom_addr,
  output logic [23:0]     rom_rdata,
  output logic [23:0]     ext_data_i
);
  logic [23:0] mem [0:16383];
  logic [7:0]  noise_r = 8'h00;
  logic [15:0] boot_a;

  // Known fill so a read from the wrong space is visible.
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = {10'h2aa, 14'(i)};
    end
  end
  // A released bus shows a moving pattern, never the last value.
  always @(posedge clk) begin
    noise_r <= noise_r + 8'h01;
    if (!ext.prog_space_select_n && !ext.wr_n) begin
      mem[ext.addr] <= ext.data_o;
    end
  end
  // The 64K byte boot space takes its top bits from the data lines.
  assign boot_a = {ext.data_o[23:22], ext.addr};
  always_comb begin
    ext_data_i = {3{noise_r}};
    if (!ext.prog_space_select_n && !ext.rd_n) begin
      ext_data_i = mem[ext.addr];
    end else if (!ext.data_space_select_n && !ext.rd_n) begin
      ext_data_i = {2'h1, ext.addr, 8'h00};
    end else if (!ext.boot_space_select_n && !ext.rd_n) begin
      ext_data_i[15:8] = boot_a[7:0] ^ boot_a[15:8] ^ 8'ha5;
    end
  end
  assign rom_rdata = {11'h4d1, rom_addr};
endmodule : pmb_mem_model
`default_nettype wire

/* File: pmb_pkg.sv */
// ==========================================================================
// Shared constants and carriers for the program memory and boot block.
// ==========================================================================
package pmb_pkg;

  // Address map of the program space and the external bus widths.
  localparam int unsigned          ADDR_W        = 14;
  localparam int unsigned          DATA_W        = 24;
  localparam int unsigned          RAM_WORDS     = 2048;
  localparam logic [13:0]          RAM_LO_BASE   = 14'h0000;
  localparam logic [13:0]          RAM_HI_BASE   = 14'h3800;
  localparam logic [13:0]          ROM_FIRST     = 14'h0800;
  localparam logic [13:0]          ROM_LAST      = 14'h27ff;
  localparam logic [13:0]          RAM_LO_LAST   = 14'h07ff;
  localparam logic [13:0]          START_ROM_PC  = 14'h0800;
  localparam logic [13:0]          START_RAM_PC  = 14'h0000;
  localparam logic [13:0]          WAIT_CTRL_DM  = 14'h3ffe;

  // Boot space: eight pages of 8K bytes, three bytes to a word.
  localparam logic [12:0]          BOOT_LAST_BYTE = 13'h17ff;
  localparam logic [10:0]          BOOT_LAST_WORD = 11'h7ff;
  localparam logic [1:0]           BYTES_PER_WORD = 2'h3;
  localparam logic [23:0]          BOOT_OE_B     = 24'h3fffff;
  localparam logic [23:0]          ALL_OE_B      = 24'hffffff;
  localparam logic [23:0]          NO_OE_B       = 24'h000000;

  // APB register byte offsets.
  localparam logic [11:0]          REG_CTRL      = 12'h000;
  localparam logic [11:0]          REG_PX        = 12'h004;
  localparam logic [11:0]          REG_STAT      = 12'h008;

  // Control register fields.
  localparam int unsigned          F_ROM_EN      = 0;
  localparam int unsigned          F_PM_WAIT     = 1;
  localparam int unsigned          F_BOOT_WAIT   = 4;
  localparam int unsigned          F_PAGE        = 7;
  localparam int unsigned          F_FORCE       = 10;
  localparam logic [2:0]           WAIT_RESET    = 3'h7;
  localparam logic [2:0]           PAGE_RESET    = 3'h0;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_STRAP = 6'h01,
    ST_BRD   = 6'h02,
    ST_BWR   = 6'h04,
    ST_HOST  = 6'h08,
    ST_RUN   = 6'h10,
    ST_EXT   = 6'h20
  } pmb_state_t;

  // Core side request and answer.
  typedef struct packed {
    logic        req;
    logic        dm_space;
    logic        we;
    logic        is_data;
    logic [13:0] addr;
    logic [23:0] wdata;
  } pmb_core_req_t;

  typedef struct packed {
    logic        ack;
    logic [23:0] rdata;
  } pmb_core_rsp_t;

  // External memory bus outputs.
  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data_o;
    logic [23:0] data_oe_b;
    logic        prog_space_select_n;
    logic        data_space_select_n;
    logic        boot_space_select_n;
    logic        rd_n;
    logic        wr_n;
  } pmb_ext_t;

endpackage : pmb_pkg

/* File: pmb_top.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Program and data cycles share external buses.
// - Fourteen bit address reaches 16K words.
// - Bidirectional 24 bit program data path.
// - Program select with read or write strobes.
// - Program space data stores take low byte from extension register.
// - Program space data loads leave low byte in extension.
// - Map low: RAM at zero, auto boot.
// - Map high: external at zero, RAM high.
// - ROM window follows the enable bit.
// - Enable resets low unless both straps high.
// - Program waits zero to seven, reset seven.
// - Boot space eight pages of 8K bytes.
// - Page field and force boot bit.
// - Map low boots page zero after reset.
// - Boot waits zero to seven, reset seven.
// - Bytes assembled into 24 bit words.
// - Boot reads use data bits 15:8 only.
// - Top data lines carry top boot address.
// - Boot mode picks host port or bytes.
// - Both straps high: ROM on, start 0x0800.
// - Wait bus request, boot, then start.
module pmb_top
  import pmb_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          map_select_pin,
  input  wire logic          boot_mode_pin,
  input  wire logic          bus_req,
  input  wire pmb_core_req_t core_req,
  output pmb_core_rsp_t      core_rsp,
  output logic               core_run,
  output logic [13:0]        core_start_pc,
  output logic [12:0]        rom_addr,
  input  wire logic [23:0]   rom_rdata,
  output logic               host_boot_req,
  input  wire logic          host_boot_done,
  output pmb_ext_t           ext,
  input  wire logic [23:0]   ext_data_i
);

  // ========================================================================
  // State and storage
  // ========================================================================
  pmb_state_t   state_r;
  logic [23:0]  ram [RAM_WORDS];
  logic         map_r;
  logic         mode_r;
  logic         rom_en_r;
  logic [2:0]   pm_wait_r;
  logic [2:0]   boot_wait_r;
  logic [2:0]   page_r;
  logic         force_r;
  logic [7:0]   prog_word_extension_reg;
  logic [2:0]   wait_cnt_r;
  logic [12:0]  byte_idx_r;
  logic [1:0]   byte_cnt_r;
  logic [10:0]  word_idx_r;
  logic [23:0]  word_r;
  logic [13:0]  addr_r;
  logic [23:0]  wdata_r;
  logic         we_r;
  logic         dm_r;
  logic         isdata_r;
  logic         ack_r;
  logic [23:0]  rdata_r;
  logic [31:0]  prdata_r;
  logic         apb_wr;
  logic         ctrl_wr;
  logic         px_wr;
  logic         accept;
  logic [1:0]   target;

  // Target codes returned by the program address decoder.
  localparam logic [1:0] TGT_EXT = 2'h0;
  localparam logic [1:0] TGT_RAM = 2'h1;
  localparam logic [1:0] TGT_ROM = 2'h2;

  // Program address decode; the ROM window overrides either map.
  function automatic logic [1:0] pm_target(input logic [13:0] a, input logic mp,
                                           input logic ren);
    if (ren && a >= ROM_FIRST && a <= ROM_LAST) begin
      pm_target = TGT_ROM;
    end else if (!mp && a <= RAM_LO_LAST) begin
      pm_target = TGT_RAM;
    end else if (mp && a >= RAM_HI_BASE) begin
      pm_target = TGT_RAM;
    end else begin
      pm_target = TGT_EXT;
    end
  endfunction : pm_target

  // Index into the 2K RAM from a program address under either map.
  function automatic logic [10:0] ram_index(input logic [13:0] a, input logic mp);
    ram_index = mp ? 11'(a - RAM_HI_BASE) : 11'(a - RAM_LO_BASE);
  endfunction : ram_index

  // ========================================================================
  // APB slave
  // ========================================================================
  // Zero wait state slave; read data is latched in the setup phase so
  // that it leaves a flip-flop during the access phase.
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign ctrl_wr = apb_wr && paddr == REG_CTRL;
  assign px_wr   = apb_wr && paddr == REG_PX;
  assign pslverr = psel && penable && paddr != REG_CTRL && paddr != REG_PX &&
                   paddr != REG_STAT;
  assign prdata  = prdata_r;

  // Read mux capture; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        REG_CTRL: prdata_r <= {21'h000000, force_r, page_r, boot_wait_r,
                               pm_wait_r, rom_en_r};
        REG_PX:   prdata_r <= {24'h000000, prog_word_extension_reg};
        REG_STAT: prdata_r <= {27'h0000000, host_boot_req, state_r == ST_BRD
                               || state_r == ST_BWR, core_run, mode_r, map_r};
        default:  prdata_r <= 32'h00000000;
      endcase
    end
  end

  // Control register. The ROM enable resets low and is raised in the
  // first cycle after release when both straps are high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_en_r    <= 1'b0;
      pm_wait_r   <= WAIT_RESET;
      boot_wait_r <= WAIT_RESET;
      page_r      <= PAGE_RESET;
    end else if (state_r == ST_STRAP) begin
      rom_en_r    <= map_select_pin && boot_mode_pin;
    end else if (ctrl_wr) begin
      rom_en_r    <= pwdata[F_ROM_EN];
      pm_wait_r   <= pwdata[F_PM_WAIT +: 3];
      boot_wait_r <= pwdata[F_BOOT_WAIT +: 3];
      page_r      <= pwdata[F_PAGE +: 3];
    end
  end

  // Force boot request; a new write wins over the clear at boot start.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      force_r <= 1'b0;
    end else if (ctrl_wr && pwdata[F_FORCE]) begin
      force_r <= 1'b1;
    end else if (state_r == ST_RUN && !core_req.req) begin
      force_r <= 1'b0;
    end
  end

  // Strap capture at each edge spent in ST_STRAP, the last being the one that sees bus_req low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map_r  <= 1'b0;
      mode_r <= 1'b0;
    end else if (state_r == ST_STRAP) begin
      map_r  <= map_select_pin;
      mode_r <= boot_mode_pin;
    end
  end

  // ========================================================================
  // Sequencer
  // ========================================================================
  // A request still standing in its own ack cycle is not taken twice.
  assign accept = state_r == ST_RUN && core_req.req && !force_r && !ack_r;
  assign target = core_req.dm_space ? TGT_EXT :
                  pm_target(core_req.addr, map_r, rom_en_r);

  // Main state machine: strap, boot, then serve core accesses.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_STRAP;
    end else begin
      case (state_r)
        ST_STRAP: begin
          if (bus_req) begin
            state_r <= ST_STRAP;
          end else if (!map_select_pin && !boot_mode_pin) begin
            state_r <= ST_BRD;
          end else if (!map_select_pin) begin
            state_r <= ST_HOST;
          end else begin
            state_r <= ST_RUN;
          end
        end
        ST_BRD: begin
          if (wait_cnt_r == 3'h0 && byte_cnt_r == BYTES_PER_WORD - 2'h1) begin
            state_r <= ST_BWR;
          end
        end
        ST_BWR: begin
          state_r <= (word_idx_r == BOOT_LAST_WORD) ? ST_RUN : ST_BRD;
        end
        ST_HOST: begin
          if (host_boot_done) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (force_r && !core_req.req) begin
            state_r <= ST_BRD;
          end else if (accept && target == TGT_EXT) begin
            state_r <= ST_EXT;
          end
        end
        ST_EXT: begin
          if (wait_cnt_r == 3'h0) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_STRAP;
      endcase
    end
  end

  // Wait state counter, loaded on entry to each external or boot cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt_r <= WAIT_RESET;
    end else if (state_r == ST_RUN || state_r == ST_BWR ||
                 state_r == ST_STRAP) begin
      wait_cnt_r <= (state_r == ST_RUN && !force_r) ? pm_wait_r
                                                      : boot_wait_r;
    end else if ((state_r == ST_BRD || state_r == ST_EXT) && wait_cnt_r != 3'h0) begin
      wait_cnt_r <= wait_cnt_r - 3'h1;
    end else if (state_r == ST_BRD) begin
      wait_cnt_r <= boot_wait_r;
    end
  end

  // Boot byte walk: ascending bytes of the page, three to a word, first
  // byte is the most significant. The boot image covers the whole RAM.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_idx_r <= 13'h0000;
      byte_cnt_r <= 2'h0;
      word_idx_r <= 11'h000;
      word_r     <= 24'h000000;
    end else if (state_r == ST_STRAP || (state_r == ST_RUN && force_r)) begin
      byte_idx_r <= 13'h0000;
      byte_cnt_r <= 2'h0;
      word_idx_r <= 11'h000;
    end else if (state_r == ST_BRD && wait_cnt_r == 3'h0) begin
      word_r     <= {word_r[15:0], ext_data_i[15:8]};
      byte_idx_r <= (byte_idx_r == BOOT_LAST_BYTE) ? byte_idx_r
                                                   : byte_idx_r + 13'h0001;
      byte_cnt_r <= (byte_cnt_r == BYTES_PER_WORD - 2'h1) ? 2'h0
                                                          : byte_cnt_r + 2'h1;
    end else if (state_r == ST_BWR) begin
      word_idx_r <= word_idx_r + 11'h001;
    end
  end

  // Internal program RAM: boot writes and core accesses.
  always_ff @(posedge clk) begin
    if (state_r == ST_BWR) begin
      ram[word_idx_r] <= word_r;
    end else if (accept && target == TGT_RAM && core_req.we) begin
      ram[ram_index(core_req.addr, map_r)] <= core_req.is_data ?
        {core_req.wdata[15:0], prog_word_extension_reg} : core_req.wdata;
    end
  end

  // Latched external request for the duration of the wait states.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r   <= 14'h0000;
      wdata_r  <= 24'h000000;
      we_r     <= 1'b0;
      dm_r     <= 1'b0;
      isdata_r <= 1'b0;
    end else if (accept) begin
      addr_r   <= core_req.addr;
      we_r     <= core_req.we;
      dm_r     <= core_req.dm_space;
      isdata_r <= core_req.is_data;
      wdata_r  <= core_req.dm_space ? {core_req.wdata[15:0], 8'h00} :
                  core_req.is_data  ? {core_req.wdata[15:0], prog_word_extension_reg}
                                    : core_req.wdata;
    end
  end

  // Core answer: one-cycle ack with read data, internal or external.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 24'h000000;
    end else if (accept && target != TGT_EXT) begin
      ack_r   <= 1'b1;
      rdata_r <= (target == TGT_ROM) ? rom_rdata
                                     : ram[ram_index(core_req.addr, map_r)];
      if (core_req.is_data) begin
        rdata_r <= (target == TGT_ROM) ? {8'h00, rom_rdata[23:8]}
                   : {8'h00, ram[ram_index(core_req.addr, map_r)][23:8]};
      end
    end else if (state_r == ST_EXT && wait_cnt_r == 3'h0) begin
      ack_r   <= 1'b1;
      rdata_r <= (dm_r || isdata_r) ? {8'h00, ext_data_i[23:8]} : ext_data_i;
    end else begin
      ack_r   <= 1'b0;
    end
  end

  // Extension register: software write, or low byte of a program space data load.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_word_extension_reg <= 8'h00;
    end else if (state_r == ST_EXT && wait_cnt_r == 3'h0 && !dm_r && isdata_r && !we_r) begin
      prog_word_extension_reg <= ext_data_i[7:0];
    end else if (accept && target == TGT_RAM && core_req.is_data && !core_req.we) begin
      prog_word_extension_reg <= ram[ram_index(core_req.addr, map_r)][7:0];
    end else if (accept && target == TGT_ROM && core_req.is_data && !core_req.we) begin
      prog_word_extension_reg <= rom_rdata[7:0];
    end else if (px_wr) begin
      prog_word_extension_reg <= pwdata[7:0];
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // The ROM port is looked up in the same cycle as the request.
  assign rom_addr      = 13'(core_req.addr - ROM_FIRST);
  assign core_rsp      = '{ack: ack_r, rdata: rdata_r};
  assign core_run      = state_r == ST_RUN || state_r == ST_EXT;
  assign core_start_pc = (map_r && mode_r) ? START_ROM_PC : START_RAM_PC;
  assign host_boot_req = state_r == ST_HOST;

  // External bus. Program and data cycles share address and data lines;
  // boot cycles put page bits 2:1 on the top two data lines. The far side
  // must gate the strobes with the selects.
  always_comb begin
    ext                     = '0;
    ext.data_oe_b           = ALL_OE_B;
    ext.prog_space_select_n = 1'b1;
    ext.data_space_select_n = 1'b1;
    ext.boot_space_select_n = 1'b1;
    ext.rd_n                = 1'b1;
    ext.wr_n                = 1'b1;
    if (state_r == ST_EXT) begin
      ext.addr                = addr_r;
      ext.data_o              = wdata_r;
      ext.data_oe_b           = we_r ? NO_OE_B : ALL_OE_B;
      ext.prog_space_select_n = dm_r;
      ext.data_space_select_n = !dm_r;
      ext.rd_n                = we_r;
      ext.wr_n                = !we_r;
    end else if (state_r == ST_BRD) begin
      ext.addr                = byte_idx_r[13 - 1:0] | {page_r[0], 13'h0000};
      ext.data_o              = {page_r[2:1], 22'h000000};
      ext.data_oe_b           = BOOT_OE_B;
      ext.boot_space_select_n = 1'b0;
      ext.rd_n                = 1'b0;
    end
  end

endmodule : pmb_top
`default_nettype wire

/* File: pmb_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench
module pmb_top_bench
  import pmb_pkg::*;
;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic map_select_pin = 0, boot_mode_pin = 0, bus_req = 1, host_boot_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, core_run, host_boot_req;
  pmb_core_req_t core_req = '0;
  pmb_core_rsp_t core_rsp;
  logic [13:0] core_start_pc;
  logic [12:0] rom_addr;
  logic [23:0] rom_rdata, ext_data_i;
  pmb_ext_t ext;
  int n_fail = 0, n_checks = 0;
  logic dm_sel = 0;

  pmb_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .map_select_pin(map_select_pin), .boot_mode_pin(boot_mode_pin), .bus_req(bus_req),
    .core_req(core_req), .core_rsp(core_rsp), .core_run(core_run),
    .core_start_pc(core_start_pc), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
    .host_boot_req(host_boot_req), .host_boot_done(host_boot_done), .ext(ext),
    .ext_data_i(ext_data_i));
  pmb_mem_model mdl (.clk(clk), .ext(ext), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
    .ext_data_i(ext_data_i));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    check(pready, 1);
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Core access. The request stands until the rising edge at which ack is
  // seen high, and the read data is taken at that same edge.
  task automatic core(input logic w, input logic dat, input logic [13:0] a,
                      input logic [23:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    core_req <= '{1'b1, dm_sel, w, dat, a, d};
    do begin @(posedge clk); n++; end while (core_rsp.ack !== 1'b1 && n < 40);
    check(core_rsp.ack, 1);
    q = {8'h0, core_rsp.rdata};
    core_req.req <= 1'b0;
  endtask : core

  task automatic restart(input logic m, input logic b);
    @(posedge clk);
    rst_b <= 0; map_select_pin <= m; boot_mode_pin <= b; bus_req <= 1;
    repeat (20) @(posedge clk);
    rst_b <= 1;
    repeat (5) @(posedge clk);
    check(core_run, 0);
    bus_req <= 0;
  endtask : restart

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (core_run !== 1'b1 && n < lim);
    check(core_run, 1);
  endtask : wait_run

  // Program word k of a boot page, three ascending bytes, first one on top.
  function automatic logic [23:0] word(input logic [2:0] p, input logic [10:0] k);
    logic [15:0] f;
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      f = {p, 13'h0} + 16'(k) * 16'd3 + 16'(i);
      r = {r[15:0], f[7:0] ^ f[15:8] ^ 8'ha5};
    end
    return r;
  endfunction : word

  task automatic test_boot;
    logic [31:0] q;
    logic e;
    restart(1'b0, 1'b0);
    wait_run(56000);
    check(core_start_pc, START_RAM_PC);
    core(1'b0, 1'b0, 14'h0000, 24'h0, q);
    check(q, word(3'h0, 11'h000));
    core(1'b0, 1'b1, 14'h07ff, 24'h0, q);
    check(q, 32'(word(3'h0, 11'h7ff) >> 8));
    apb(1'b0, REG_PX, 32'h0, q, e);
    check(q, 32'(word(3'h0, 11'h7ff) & 24'hff));
    apb(1'b1, REG_CTRL, 32'h68e, q, e);
    repeat (3) @(posedge clk);
    check(core_run, 0);
    wait_run(12000);
    core(1'b0, 1'b0, 14'h0000, 24'h0, q);
    check(q, word(3'h5, 11'h000));
    apb(1'b0, REG_CTRL, 32'h0, q, e);
    check(q, 32'h28e);
    $display("test_boot done");
  endtask : test_boot

  task automatic test_ext;
    logic [31:0] q;
    logic e;
    restart(1'b1, 1'b0);
    wait_run(20);
    apb(1'b0, REG_CTRL, 32'h0, q, e);
    check(q, 32'h7e);
    apb(1'b1, REG_CTRL, 32'h70, q, e);
    apb(1'b1, REG_PX, 32'h3c, q, e);
    core(1'b1, 1'b1, 14'h0100, 24'h001234, q);
    check(mdl.mem[256], 24'h12343c);
    apb(1'b1, REG_PX, 32'h0, q, e);
    core(1'b0, 1'b1, 14'h0100, 24'h0, q);
    check(q, 32'h1234);
    dm_sel = 1'b1;
    core(1'b0, 1'b1, 14'h0123, 24'h0, q);
    dm_sel = 1'b0;
    check(q, 32'h4123);
    apb(1'b0, REG_PX, 32'h0, q, e);
    check(q, 32'h3c);
    core(1'b0, 1'b0, 14'h0900, 24'h0, q);
    check(q, {10'h2aa, 14'h0900});
    apb(1'b1, REG_CTRL, 32'h71, q, e);
    core(1'b0, 1'b0, 14'h0900, 24'h0, q);
    check(q, {11'h4d1, 13'h0100});
    core(1'b1, 1'b1, 14'h3800, 24'h00beef, q);
    core(1'b0, 1'b0, 14'h3800, 24'h0, q);
    check(q, 32'hbeef3c);
    check(mdl.mem[14336], {10'h2aa, 14'h3800});
    apb(1'b0, 12'h00c, 32'h0, q, e);
    check({q, e}, 33'h1);
    $display("test_ext done");
  endtask : test_ext

  task automatic test_rom_host;
    logic [31:0] q;
    logic e;
    restart(1'b1, 1'b1);
    wait_run(20);
    check(core_start_pc, START_ROM_PC);
    apb(1'b0, REG_CTRL, 32'h0, q, e);
    check(q, 32'h7f);
    core(1'b0, 1'b0, 14'h0800, 24'h0, q);
    check(q, {11'h4d1, 13'h0000});
    restart(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    check({host_boot_req, core_run}, 2'b10);
    host_boot_done <= 1;
    @(posedge clk);
    host_boot_done <= 0;
    wait_run(20);
    check(core_start_pc, START_RAM_PC);
    $display("test_rom_host done");
  endtask : test_rom_host

  // Watchdog: the boots dominate, about 59500 cycles in all.
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    test_boot();
    test_ext();
    test_rom_host();
    test_done();
  end
endmodule : pmb_top_bench
`default_nettype wire

/* File: pmb_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Checker on the external bus and core port
module pmb_props
  import pmb_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          map_select_pin,
  input wire logic          boot_mode_pin,
  input wire pmb_core_req_t core_req,
  input wire pmb_core_rsp_t core_rsp,
  input wire logic          core_run,
  input wire logic [13:0]   core_start_pc,
  input wire logic [12:0]   rom_addr,
  input wire logic          host_boot_req,
  input wire pmb_ext_t      ext
);
  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_qualified_a: assert property (!ext.rd_n |-> !(ext.prog_space_select_n &&
    ext.data_space_select_n && ext.boot_space_select_n)) else $error("bare read strobe");
  wr_qualified_a: assert property (!ext.wr_n |-> ext.boot_space_select_n &&
    !(ext.prog_space_select_n && ext.data_space_select_n)) else $error("bare write strobe");
  boot_lines_a: assert property (!ext.boot_space_select_n |->
    ext.data_oe_b == BOOT_OE_B && ext.wr_n) else $error("boot cycle bus drive wrong");
  read_float_a: assert property (!ext.prog_space_select_n && !ext.rd_n |->
    ext.data_oe_b == ALL_OE_B) else $error("data driven during read");
  write_drive_a: assert property (!ext.wr_n |-> ext.data_oe_b == NO_OE_B)
    else $error("data not driven during write");
  ext_ack_time_a: assert property ($fell(ext.prog_space_select_n) |-> ##[1:8]
    core_rsp.ack) else $error("external access too long");
  rom_index_a: assert property (rom_addr == 13'(core_req.addr - ROM_FIRST))
    else $error("rom index wrong");
  start_pc_a: assert property ($rose(core_run) |-> core_start_pc ==
    ((map_select_pin && boot_mode_pin) ? START_ROM_PC : START_RAM_PC)) else $error("bad start");
  host_hold_a: assert property (host_boot_req |-> !core_run && ext.boot_space_select_n)
    else $error("host boot overlaps");
  boot_quiet_a: assert property (!ext.boot_space_select_n |-> !core_run &&
    ext.prog_space_select_n) else $error("boot overlaps run");
  // The main paths, so a silent run shows up as missing coverage.
  run_c: cover property ($rose(core_run));
  ack_c: cover property (!ext.prog_space_select_n ##1 core_rsp.ack);
  boot_c: cover property (!ext.boot_space_select_n && !ext.rd_n);
endmodule : pmb_props

bind pmb_top pmb_props chk (.clk(clk), .rst_b(rst_b), .map_select_pin(map_select_pin),
  .boot_mode_pin(boot_mode_pin), .core_req(core_req), .core_rsp(core_rsp),
  .core_run(core_run), .core_start_pc(core_start_pc), .rom_addr(rom_addr),
  .host_boot_req(host_boot_req), .ext(ext));
`default_nettype wire
